/* verilog/cad_regs.vh */
// Constants for the core datapath: opcodes, flag bits, address map, timing
// Operation
// - Separate buses; prefetch next while executing
// - Thirty-two 8-bit registers, single-cycle access
// - Register/immediate arithmetic completes in one cycle
// - Flags updated after every ALU operation except MOV and LDI
// - Six registers form three 16-bit pointers
// - Program bus starts flash at zero
// - Lowest 4KB data space is I/O
// - Lowest 64 I/O reachable directly, single cycle
// - Lowest 32 I/O support bit ops
// - 0x0040-0x0FFF reachable only by load/store
// - 0x1000-0x17FF reserved for fuses, NVM
// - 0x1800-0x7FFF reserved for RAM, others
// - Flash mapped into data space from 0x8000
// - Program load reads flash code-space addressed
// - Multiplier: two 8-bit operands, 16-bit product
// - Signed, unsigned, mixed, integer and fractional multiply
// - Every multiplication takes exactly two cycles
// - ALU does 8/16-bit, one/two operand ops
// - Unified data space up to 64KB
// - 16-bit I/O accessed as true 16-bit
// - Fetch starts at address 0x0000 after reset
// - Core clock used directly, no division
`ifndef CAD_REGS_VH
`define CAD_REGS_VH
// Operation codes on i_op
`define CAD_OP_NOP 5'h00
`define CAD_OP_ADD 5'h01
`define CAD_OP_ADC 5'h02
`define CAD_OP_SUB 5'h03
`define CAD_OP_SBC 5'h04
`define CAD_OP_AND 5'h05
`define CAD_OP_OR 5'h06
`define CAD_OP_EOR 5'h07
`define CAD_OP_MOV 5'h08
`define CAD_OP_COM 5'h09
`define CAD_OP_NEG 5'h0A
`define CAD_OP_INC 5'h0B
`define CAD_OP_DEC 5'h0C
`define CAD_OP_LSR 5'h0D
`define CAD_OP_ADIW 5'h0E
`define CAD_OP_SBIW 5'h0F
`define CAD_OP_MUL 5'h10
`define CAD_OP_LOAD 5'h11
`define CAD_OP_STORE 5'h12
`define CAD_OP_IN 5'h13
`define CAD_OP_OUT 5'h14
`define CAD_OP_BSET 5'h15
`define CAD_OP_BCLR 5'h16
`define CAD_OP_BTST 5'h17
`define CAD_OP_LPM 5'h18
`define CAD_OP_LDI 5'h19
`define CAD_OP_CP 5'h1A
// Multiply modes on i_mul_mode: bit2 fractional, bit1 a signed, bit0 b signed
`define CAD_MUL_FRAC 2
`define CAD_MUL_ASGN 1
`define CAD_MUL_BSGN 0
// Flag bit positions
`define CAD_FLAG_C 0
`define CAD_FLAG_Z 1
`define CAD_FLAG_N 2
`define CAD_FLAG_V 3
`define CAD_FLAG_S 4
`define CAD_FLAG_H 5
`define CAD_FLAGS_RST 8'h00
// Pointer register numbers (low byte)
`define CAD_PTR_X 5'h1A
`define CAD_PTR_Y 5'h1C
`define CAD_PTR_Z 5'h1E
// Data address map
`define CAD_IO_END 16'h1000
`define CAD_IO_DIRECT_END 16'h0040
`define CAD_IO_BIT_END 16'h0020
`define CAD_NVM_BASE 16'h1000
`define CAD_RAM_BASE 16'h1800
`define CAD_FLASH_BASE 16'h8000
`define CAD_RESET_PC 16'h0000
// Region codes on o_dmem_region
`define CAD_REG_IO 2'h0
`define CAD_REG_NVM 2'h1
`define CAD_REG_RAM 2'h2
`define CAD_REG_FLASH 2'h3
// Multiplier latency in core cycles
`define CAD_MUL_CYCLES 2'h2
`endif

/* verilog/cad_core.v */
// Core datapath: prefetch, register file, ALU, multiplier, data address decode
`timescale 1ns/1ps
`include "cad_regs.vh"
module cad_core (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire i_issue,
  input wire [4:0] i_op,
  input wire [4:0] i_rd,
  input wire [4:0] i_rr,
  input wire [7:0] i_imm,
  input wire [2:0] i_bit,
  input wire [2:0] i_mul_mode,
  input wire [1:0] i_ptr_sel,
  input wire i_addr_direct,
  input wire [15:0] i_addr,
  input wire i_wide,
  input wire i_pc_load,
  input wire [15:0] i_pc_target,
  input wire [15:0] i_pmem_rdata,
  input wire [15:0] i_dmem_rdata,
  input wire [7:0] i_io_rdata,
  output wire o_busy,
  output reg [15:0] o_pmem_addr,
  output reg [15:0] o_instr,
  output reg o_instr_valid,
  output reg [15:0] o_dmem_addr,
  output reg [15:0] o_dmem_wdata,
  output reg o_dmem_we,
  output reg o_dmem_re,
  output reg o_dmem_wide,
  output reg [1:0] o_dmem_region,
  output reg [5:0] o_io_addr,
  output reg [7:0] o_io_wdata,
  output reg o_io_we,
  output reg o_io_re,
  output reg o_io_bit_op,
  output reg o_skip,
  output reg [7:0] o_flags,
  output reg o_mul_done,
  output reg [15:0] o_mul_result
);

  // Cycle stays the raw core clock; nothing here divides it

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function [15:0] cad_ptr;
    input [2:0] unused;
    input [7:0] lo;
    input [7:0] hi;
    begin
      cad_ptr = {hi, lo};
    end
  endfunction

  function [7:0] cad_zns;
    input [7:0] res;
    input c;
    input v;
    input h;
    input [7:0] old;
    reg n;
    begin
      n = res[7];
      cad_zns = old;
      cad_zns[`CAD_FLAG_C] = c;
      cad_zns[`CAD_FLAG_Z] = (res == 8'h00);
      cad_zns[`CAD_FLAG_N] = n;
      cad_zns[`CAD_FLAG_V] = v;
      cad_zns[`CAD_FLAG_S] = n ^ v;
      cad_zns[`CAD_FLAG_H] = h;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file: 32 x 8, ALU results written in the same cycle the op is issued
  reg [7:0] gpr [0:31];
  reg [1:0] mul_cnt;
  reg [15:0] pc_save;
  reg [2:0] mul_mode;
  reg [7:0] mul_a;
  reg [7:0] mul_b;

  assign o_busy = (mul_cnt != 2'h0);
  wire take = i_issue && !o_busy;
  wire [7:0] opa = gpr[i_rd];
  wire [7:0] opb = gpr[i_rr];

  // Pointer pairs X, Y, Z
  wire [15:0] ptr_x = cad_ptr(3'h0, gpr[`CAD_PTR_X], gpr[`CAD_PTR_X + 5'h01]);
  wire [15:0] ptr_y = cad_ptr(3'h0, gpr[`CAD_PTR_Y], gpr[`CAD_PTR_Y + 5'h01]);
  wire [15:0] ptr_z = cad_ptr(3'h0, gpr[`CAD_PTR_Z], gpr[`CAD_PTR_Z + 5'h01]);
  reg [15:0] ptr_sel;
  always @*
  begin
    case (i_ptr_sel)
      2'h0: ptr_sel = ptr_x;
      2'h1: ptr_sel = ptr_y;
      default: ptr_sel = ptr_z;
    endcase
  end
  // Full 16-bit address space, direct or through a pointer
  wire [15:0] daddr = i_addr_direct ? i_addr : ptr_sel;
  wire [15:0] rd_pair = {gpr[i_rd + 5'h01], gpr[i_rd]};

  ////////////////////////////////////////////////////////////////////////////
  // ALU, combinational, single cycle
  reg [7:0] alu_res;
  reg [15:0] alu_res16;
  reg alu_wr;
  reg alu_wr16;
  reg [7:0] next_flags;
  reg [8:0] sum;
  reg [7:0] rhs;
  reg [16:0] sum16;
  always @*
  begin
    alu_res = 8'h00;
    alu_res16 = 16'h0000;
    alu_wr = 1'b0;
    alu_wr16 = 1'b0;
    next_flags = o_flags;
    sum = 9'h000;
    sum16 = 17'h00000;
    rhs = (i_op == `CAD_OP_ADD || i_op == `CAD_OP_ADC || i_op == `CAD_OP_SUB ||
           i_op == `CAD_OP_SBC || i_op == `CAD_OP_CP) ? opb : i_imm;
    case (i_op)
      `CAD_OP_ADD, `CAD_OP_ADC:
      begin
        sum = {1'b0, opa} + {1'b0, rhs} +
              {8'h00, (i_op == `CAD_OP_ADC) & o_flags[`CAD_FLAG_C]};
        alu_res = sum[7:0];
        alu_wr = 1'b1;
        next_flags = cad_zns(alu_res, sum[8], (opa[7] == rhs[7]) && (alu_res[7] != opa[7]),
                             (opa[3] & rhs[3]) | (rhs[3] & ~alu_res[3]) | (~alu_res[3] & opa[3]),
                             o_flags);
      end
      `CAD_OP_SUB, `CAD_OP_SBC, `CAD_OP_CP:
      begin
        sum = {1'b0, opa} - {1'b0, rhs} -
              {8'h00, (i_op == `CAD_OP_SBC) & o_flags[`CAD_FLAG_C]};
        alu_res = sum[7:0];
        alu_wr = (i_op != `CAD_OP_CP);
        next_flags = cad_zns(alu_res, sum[8], (opa[7] != rhs[7]) && (alu_res[7] != opa[7]),
                             (~opa[3] & rhs[3]) | (rhs[3] & alu_res[3]) | (alu_res[3] & ~opa[3]),
                             o_flags);
      end
      `CAD_OP_AND, `CAD_OP_OR, `CAD_OP_EOR:
      begin
        alu_res = (i_op == `CAD_OP_AND) ? (opa & opb) : (i_op == `CAD_OP_OR) ? (opa | opb) : (opa ^ opb);
        alu_wr = 1'b1;
        next_flags = cad_zns(alu_res, o_flags[`CAD_FLAG_C], 1'b0, o_flags[`CAD_FLAG_H], o_flags);
      end
      `CAD_OP_MOV, `CAD_OP_LDI:
      begin
        alu_res = (i_op == `CAD_OP_MOV) ? opb : i_imm;
        alu_wr = 1'b1;
      end
      // Single-register operations
      `CAD_OP_COM:
      begin
        alu_res = ~opa;
        alu_wr = 1'b1;
        next_flags = cad_zns(alu_res, 1'b1, 1'b0, o_flags[`CAD_FLAG_H], o_flags);
      end
      `CAD_OP_NEG:
      begin
        alu_res = 8'h00 - opa;
        alu_wr = 1'b1;
        next_flags = cad_zns(alu_res, alu_res != 8'h00, alu_res == 8'h80, alu_res[3] | opa[3], o_flags);
      end
      `CAD_OP_INC, `CAD_OP_DEC:
      begin
        alu_res = (i_op == `CAD_OP_INC) ? opa + 8'h01 : opa - 8'h01;
        alu_wr = 1'b1;
        next_flags = cad_zns(alu_res, o_flags[`CAD_FLAG_C],
                             (i_op == `CAD_OP_INC) ? (alu_res == 8'h80) : (alu_res == 8'h7F),
                             o_flags[`CAD_FLAG_H], o_flags);
      end
      `CAD_OP_LSR:
      begin
        alu_res = {1'b0, opa[7:1]};
        alu_wr = 1'b1;
        next_flags = cad_zns(alu_res, opa[0], opa[0], o_flags[`CAD_FLAG_H], o_flags);
      end
      // 16-bit add/subtract of an immediate to a register pair
      `CAD_OP_ADIW, `CAD_OP_SBIW:
      begin
        sum16 = (i_op == `CAD_OP_ADIW) ? {1'b0, rd_pair} + {9'h000, i_imm} : {1'b0, rd_pair} - {9'h000, i_imm};
        alu_res16 = sum16[15:0];
        alu_wr16 = 1'b1;
        next_flags[`CAD_FLAG_C] = sum16[16];
        next_flags[`CAD_FLAG_Z] = (alu_res16 == 16'h0000);
        next_flags[`CAD_FLAG_N] = alu_res16[15];
        next_flags[`CAD_FLAG_V] = (i_op == `CAD_OP_ADIW) ? (~rd_pair[15] & alu_res16[15]) : (rd_pair[15] & ~alu_res16[15]);
        next_flags[`CAD_FLAG_S] = alu_res16[15] ^ next_flags[`CAD_FLAG_V];
      end
      default:
      begin
        alu_res = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiplier product, formed in the second cycle
  wire signed [8:0] ma = {mul_mode[`CAD_MUL_ASGN] & mul_a[7], mul_a};
  wire signed [8:0] mb = {mul_mode[`CAD_MUL_BSGN] & mul_b[7], mul_b};
  wire signed [17:0] mprod = ma * mb;
  wire [15:0] mres = mul_mode[`CAD_MUL_FRAC] ? {mprod[14:0], 1'b0} : mprod[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Data address decode
  wire is_mem = (i_op == `CAD_OP_LOAD) || (i_op == `CAD_OP_STORE);
  wire is_io = (i_op == `CAD_OP_IN) || (i_op == `CAD_OP_OUT);
  wire is_bit = (i_op == `CAD_OP_BSET) || (i_op == `CAD_OP_BCLR) || (i_op == `CAD_OP_BTST);
  wire io_ok = (i_imm < `CAD_IO_DIRECT_END);
  wire bit_ok = (i_imm < `CAD_IO_BIT_END);
  reg [1:0] region;
  always @*
  begin
    if (daddr < `CAD_IO_END)
      region = `CAD_REG_IO;
    else if (daddr < `CAD_RAM_BASE)
      region = `CAD_REG_NVM;
    else if (daddr < `CAD_FLASH_BASE)
      region = `CAD_REG_RAM;
    else
      region = `CAD_REG_FLASH;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending load target, data returns in the same cycle as the strobe
  reg ld_pend;
  reg ld_wide;
  reg ld_io;
  reg [4:0] ld_rd;
  reg lpm_pend;
  reg lpm_hi;
  integer k;

  // Main sequential process
  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (k = 0; k < 32; k = k + 1)
        gpr[k] <= 8'h00;
      o_flags <= `CAD_FLAGS_RST;
      o_pmem_addr <= `CAD_RESET_PC;
      o_instr <= 16'h0000;
      o_instr_valid <= 1'b0;
      o_dmem_addr <= 16'h0000;
      o_dmem_wdata <= 16'h0000;
      o_dmem_we <= 1'b0;
      o_dmem_re <= 1'b0;
      o_dmem_wide <= 1'b0;
      o_dmem_region <= `CAD_REG_IO;
      o_io_addr <= 6'h00;
      o_io_wdata <= 8'h00;
      o_io_we <= 1'b0;
      o_io_re <= 1'b0;
      o_io_bit_op <= 1'b0;
      o_skip <= 1'b0;
      o_mul_done <= 1'b0;
      o_mul_result <= 16'h0000;
      mul_cnt <= 2'h0;
      pc_save <= 16'h0000;
      mul_mode <= 3'h0;
      mul_a <= 8'h00;
      mul_b <= 8'h00;
      ld_pend <= 1'b0;
      ld_wide <= 1'b0;
      ld_io <= 1'b0;
      ld_rd <= 5'h00;
      lpm_pend <= 1'b0;
      lpm_hi <= 1'b0;
    end
    else
    begin
      // Prefetch: fetched word latched while the previous one executes
      o_instr <= i_pmem_rdata;
      o_instr_valid <= 1'b1;
      if (lpm_pend)
        o_pmem_addr <= pc_save; // Fetch resumes after the one-cycle steal
      else if (i_pc_load)
        o_pmem_addr <= i_pc_target;
      else if (!o_busy)
        o_pmem_addr <= o_pmem_addr + 16'h0001;
      o_dmem_we <= 1'b0;
      o_dmem_re <= 1'b0;
      o_io_we <= 1'b0;
      o_io_re <= 1'b0;
      o_io_bit_op <= 1'b0;
      o_skip <= 1'b0;
      o_mul_done <= 1'b0;
      ld_pend <= 1'b0;
      lpm_pend <= 1'b0;
      // Load data write-back
      if (ld_pend)
      begin
        gpr[ld_rd] <= ld_io ? i_io_rdata : i_dmem_rdata[7:0];
        if (ld_wide)
          gpr[ld_rd + 5'h01] <= i_dmem_rdata[15:8];
      end
      if (lpm_pend)
        gpr[ld_rd] <= lpm_hi ? i_pmem_rdata[15:8] : i_pmem_rdata[7:0];
      // Multiplier: operands captured, product written after two cycles
      if (mul_cnt == 2'h1)
      begin
        gpr[5'h00] <= mres[7:0];
        gpr[5'h01] <= mres[15:8];
        o_mul_result <= mres;
        o_mul_done <= 1'b1;
        o_flags[`CAD_FLAG_C] <= mul_mode[`CAD_MUL_FRAC] ? mprod[15] : mres[15];
        o_flags[`CAD_FLAG_Z] <= (mres == 16'h0000);
        mul_cnt <= 2'h0;
      end
      else if (mul_cnt != 2'h0)
        mul_cnt <= mul_cnt - 2'h1;
      if (take)
      begin
        if (alu_wr)
          gpr[i_rd] <= alu_res;
        if (alu_wr16)
        begin
          gpr[i_rd] <= alu_res16[7:0];
          gpr[i_rd + 5'h01] <= alu_res16[15:8];
        end
        o_flags <= next_flags;
        if (i_op == `CAD_OP_MUL)
        begin
          mul_a <= opa;
          mul_b <= opb;
          mul_mode <= i_mul_mode;
          mul_cnt <= `CAD_MUL_CYCLES;
        end
        if (is_mem)
        begin
          o_dmem_addr <= daddr;
          o_dmem_region <= region;
          o_dmem_wide <= i_wide;
          o_dmem_wdata <= {i_wide ? gpr[i_rd + 5'h01] : 8'h00, opa};
          o_dmem_we <= (i_op == `CAD_OP_STORE);
          o_dmem_re <= (i_op == `CAD_OP_LOAD);
          ld_pend <= (i_op == `CAD_OP_LOAD);
          ld_wide <= i_wide;
          ld_io <= 1'b0;
          ld_rd <= i_rd;
        end
        if (is_io && io_ok)
        begin
          o_io_addr <= i_imm[5:0];
          o_io_wdata <= opa;
          o_io_we <= (i_op == `CAD_OP_OUT);
          o_io_re <= (i_op == `CAD_OP_IN);
          ld_pend <= (i_op == `CAD_OP_IN);
          ld_wide <= 1'b0;
          ld_io <= 1'b1;
          ld_rd <= i_rd;
        end
        if (is_bit && bit_ok)
        begin
          o_io_addr <= i_imm[5:0];
          o_io_bit_op <= 1'b1;
          o_io_wdata <= (i_io_rdata & ~(8'h01 << i_bit)) | ((i_op == `CAD_OP_BSET) ? (8'h01 << i_bit) : 8'h00);
          o_io_we <= (i_op != `CAD_OP_BTST);
          o_io_re <= 1'b1;
          o_skip <= (i_op == `CAD_OP_BTST) && (i_io_rdata[i_bit] == i_mul_mode[0]);
        end
        if (i_op == `CAD_OP_LPM)
        begin
          o_pmem_addr <= {1'b0, ptr_z[15:1]};
          pc_save <= o_pmem_addr + 16'h0001;
          lpm_pend <= 1'b1;
          lpm_hi <= ptr_z[0];
          ld_rd <= i_rd;
        end
      end
    end
  end

endmodule // cad_core

/* tb/cad_core_assertions.sv */
// Port-level checker of the core datapath
`timescale 1ns/1ps
`include "cad_regs.vh"
module cad_core_assertions (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire i_issue,
  input wire [4:0] i_op,
  input wire [7:0] i_imm,
  input wire i_addr_direct,
  input wire [15:0] i_addr,
  input wire i_wide,
  input wire i_pc_load,
  input wire o_busy,
  input wire [15:0] o_pmem_addr,
  input wire o_dmem_we,
  input wire o_dmem_re,
  input wire [15:0] o_dmem_addr,
  input wire o_dmem_wide,
  input wire [1:0] o_dmem_region,
  input wire o_io_re,
  input wire o_io_bit_op,
  input wire o_mul_done
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Request taken this edge
  wire go = i_issue && !o_busy;
  // Fetch starts at zero, then streams word by word
  chk_reset_fetch: assert property ($rose(i_rstn) |-> o_pmem_addr == 16'h0000 ##1 o_pmem_addr == 16'h0001)
    else $error("fetch did not start at zero");
  chk_fetch_step: assert property ((!i_issue && !i_pc_load && !o_busy) [*2] |=>
    o_pmem_addr == $past(o_pmem_addr) + 16'h0001) else $error("prefetch did not advance");
  chk_mul_two: assert property (go && i_op == `CAD_OP_MUL |=> o_busy [*2] ##1 (!o_busy && o_mul_done))
    else $error("multiply not two cycles");
  chk_io_range: assert property (go && i_op == `CAD_OP_IN |=> o_io_re == ($past(i_imm) < 8'h40))
    else $error("io read range wrong");
  chk_bit_range: assert property (go && (i_op == `CAD_OP_BSET || i_op == `CAD_OP_BCLR) |=>
    o_io_bit_op == ($past(i_imm) < 8'h20)) else $error("bit op range wrong");
  // Region from the address; the I/O cut is at 4KB
  chk_region_map: assert property (o_dmem_re || o_dmem_we |-> o_dmem_region ==
    (o_dmem_addr >= `CAD_FLASH_BASE ? `CAD_REG_FLASH : o_dmem_addr >= `CAD_RAM_BASE ? `CAD_REG_RAM :
    o_dmem_addr >= `CAD_NVM_BASE ? `CAD_REG_NVM : `CAD_REG_IO)) else $error("region decode wrong");
  chk_store_addr: assert property (go && i_op == `CAD_OP_STORE && i_addr_direct |=> o_dmem_we &&
    o_dmem_addr == $past(i_addr) && o_dmem_wide == $past(i_wide)) else $error("store address wrong");
  chk_lpm_code: assert property (go && i_op == `CAD_OP_LPM |=> !o_dmem_re && !o_dmem_we)
    else $error("program load used data bus");
endmodule // cad_core_assertions

/* tb/cad_mem_model.sv */
// Far-side model: program flash and data memory
`timescale 1ns/1ps
module cad_mem_model (
  input wire i_clk_sys,
  input wire [15:0] i_pmem_addr,
  input wire [15:0] i_dmem_addr,
  input wire i_dmem_re,
  input wire [7:0] i_imm,
  output wire [15:0] o_pmem_rdata,
  output wire [15:0] o_dmem_rdata,
  output wire [7:0] o_io_rdata
);
  reg [15:0] held = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // Flash word by word address from zero; data only while read, else toggling
  assign o_pmem_rdata = {i_pmem_addr[7:0] ^ 8'h5A, i_pmem_addr[7:0]};
  assign o_dmem_rdata = i_dmem_re ? {~i_dmem_addr[7:0], i_dmem_addr[7:0]} : ~held;
  assign o_io_rdata = {2'h2, i_imm[5:0]};
  // Last value, so an idle bus never repeats it
  always @(posedge i_clk_sys)
  begin
    held <= o_dmem_rdata;
  end
endmodule // cad_mem_model

/* tb/test_cpu_alu_datapath.sv */
// Self-checking bench of the core datapath
`timescale 1ns/1ps
`include "cad_regs.vh"
module test_cpu_alu_datapath;
  logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_issue = 1'b0, i_addr_direct = 1'b0, i_wide = 1'b0, i_pc_load = 1'b0;
  logic [4:0] i_op = 5'h00, i_rd = 5'h00, i_rr = 5'h00;
  logic [7:0] i_imm = 8'h00;
  logic [2:0] i_bit = 3'h0, i_mul_mode = 3'h0;
  logic [1:0] i_ptr_sel = 2'h0;
  logic [15:0] i_addr = 16'h0000, i_pc_target = 16'h0000;
  wire [15:0] i_pmem_rdata, i_dmem_rdata, o_pmem_addr, o_instr, o_dmem_addr, o_dmem_wdata, o_mul_result;
  wire [7:0] i_io_rdata, o_io_wdata, o_flags;
  wire [5:0] o_io_addr;
  wire [1:0] o_dmem_region;
  wire o_busy, o_instr_valid, o_dmem_we, o_dmem_re, o_dmem_wide, o_io_we, o_io_re, o_io_bit_op, o_skip, o_mul_done;
  int failures = 0, checked = 0;
  cad_core i_dut (.*);
  cad_mem_model i_mem (.i_clk_sys(i_clk_sys), .i_pmem_addr(o_pmem_addr), .i_dmem_addr(o_dmem_addr),
    .i_dmem_re(o_dmem_re), .i_imm(i_imm), .o_pmem_rdata(i_pmem_rdata), .o_dmem_rdata(i_dmem_rdata),
    .o_io_rdata(i_io_rdata));
  // 40 MHz core clock
  initial
  begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One request, launched at an edge; held until the next call or idle
  task automatic op(input logic [4:0] o, d, r = 5'h00, input logic [7:0] m = 8'h00,
    input logic [15:0] a = 16'h1900, input logic [2:0] md = 3'h0, input logic w = 1'b0, dr = 1'b1);
    @(posedge i_clk_sys);
    i_issue <= 1'b1;
    i_op <= o;
    i_rd <= d;
    i_rr <= r;
    i_imm <= m;
    i_addr <= a;
    i_bit <= md;
    i_mul_mode <= md;
    i_wide <= w;
    i_addr_direct <= dr;
  endtask
  // Lets the taking edge pass, then samples settled outputs
  task automatic idle;
    @(posedge i_clk_sys);
    i_issue <= 1'b0;
    #1;
  endtask
  // Register contents only show through a store
  task automatic st(input logic [4:0] d, input logic [15:0] x, input logic w = 1'b0);
    op(`CAD_OP_STORE, d, 5'h00, 8'h00, 16'h1900, 3'h0, w);
    idle;
    cmp("store strobe", 16'h0001, o_dmem_we);
    cmp("store data", x, w ? o_dmem_wdata : {8'h00, o_dmem_wdata[7:0]});
  endtask
  task automatic final_report;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_fetch;
    logic [7:0] j;
    cmp("reset fetch address", 16'h0000, o_pmem_addr);
    for (int k = 1; k < 4; k++)
    begin
      @(posedge i_clk_sys);
      #1;
      j = k - 1;
      cmp("fetch address", k, o_pmem_addr);
      cmp("prefetched word", {j ^ 8'h5A, j}, o_instr);
      cmp("fetch valid", 16'h0001, o_instr_valid);
    end
    @(posedge i_clk_sys);
    i_pc_load <= 1'b1;
    i_pc_target <= 16'h0040;
    @(posedge i_clk_sys);
    i_pc_load <= 1'b0;
    #1;
    cmp("jump target", 16'h0040, o_pmem_addr);
  endtask
  // Back-to-back results feed the next op without a gap
  task automatic s_alu;
    op(`CAD_OP_LDI, 5'h10, 5'h00, 8'hF0);
    op(`CAD_OP_LDI, 5'h11, 5'h00, 8'h10);
    op(`CAD_OP_ADD, 5'h10, 5'h11);
    idle;
    cmp("add flags", 16'h0003, o_flags & 8'h07);
    st(5'h10, 16'h0000);
    op(`CAD_OP_LDI, 5'h12, 5'h00, 8'h03);
    op(`CAD_OP_SUB, 5'h12, 5'h11);
    idle;
    cmp("sub flags", 16'h0005, o_flags & 8'h07);
    st(5'h12, 16'h00F3);
  endtask
  task automatic s_word;
    logic [15:0] a[7] = '{16'h0FFF, 16'h1000, 16'h17FF, 16'h1800, 16'h7FFF, 16'h8000, 16'hFFFF};
    logic [13:0] g = 14'b11_11_10_10_01_01_00;
    op(`CAD_OP_LDI, 5'h1A, 5'h00, 8'hFF);
    op(`CAD_OP_LDI, 5'h1B, 5'h00, 8'h00);
    op(`CAD_OP_ADIW, 5'h1A, 5'h00, 8'h01);
    op(`CAD_OP_LOAD, 5'h09, 5'h00, 8'h00, 16'h0000, 3'h0, 1'b0, 1'b0);
    idle;
    cmp("pointer address", 16'h0100, o_dmem_addr);
    st(5'h1A, 16'h0100, 1'b1);
    for (int k = 0; k < 7; k++)
    begin
      op(`CAD_OP_LOAD, 5'h09, 5'h00, 8'h00, a[k]);
      idle;
      cmp("region", g[2 * k +: 2], o_dmem_region);
    end
    st(5'h09, 16'h00FF);
  endtask
  task automatic s_mul;
    logic [2:0] md[5] = '{3'h0, 3'h3, 3'h2, 3'h4, 3'h6};
    logic [15:0] e[5] = '{16'h02FA, 16'hFFFA, 16'hFFFA, 16'h05F4, 16'hFFF4};
    int n;
    op(`CAD_OP_LDI, 5'h14, 5'h00, 8'hFE);
    op(`CAD_OP_LDI, 5'h15, 5'h00, 8'h03);
    for (int k = 0; k < 5; k++)
    begin
      op(`CAD_OP_MUL, 5'h14, 5'h15, 8'h00, 16'h1900, md[k]);
      idle;
      n = 0;
      while (o_mul_done !== 1'b1 && n < 4)
      begin
        @(posedge i_clk_sys);
        #1;
        n++;
      end
      if (n == 4)
      begin
        failures++;
        final_report;
      end
      cmp("multiply cycles", 16'h0002, n);
      cmp("product", e[k], o_mul_result);
    end
  endtask
  // Out-of-range I/O numbers must be ignored
  task automatic s_io;
    logic [4:0] o[5] = '{`CAD_OP_IN, `CAD_OP_IN, `CAD_OP_BSET, `CAD_OP_BCLR, `CAD_OP_BSET};
    logic [7:0] m[5] = '{8'h3F, 8'h40, 8'h1F, 8'h1F, 8'h20};
    logic [2:0] b[5] = '{3'h0, 3'h0, 3'h6, 3'h7, 3'h0};
    logic [7:0] w[5] = '{8'h00, 8'h00, 8'hDF, 8'h1F, 8'h00};
    logic [1:0] e[5] = '{2'h2, 2'h0, 2'h3, 2'h3, 2'h0};
    for (int k = 0; k < 5; k++)
    begin
      op(o[k], 5'h07, 5'h00, m[k], 16'h1900, b[k]);
      idle;
      cmp("io strobes", e[k], {o_io_re, o_io_bit_op});
      if (e[k][0])
        cmp("bit write", w[k], o_io_wdata);
    end
  endtask
  // Op table on a copy of r22 against r23; flags masked to C Z N V
  task automatic s_ops;
    logic [4:0] o[12] = '{`CAD_OP_CP, `CAD_OP_NEG, `CAD_OP_ADC, `CAD_OP_COM, `CAD_OP_SBC, `CAD_OP_AND,
      `CAD_OP_OR, `CAD_OP_EOR, `CAD_OP_INC, `CAD_OP_DEC, `CAD_OP_LSR, `CAD_OP_SBIW};
    logic [7:0] r[12] = '{8'h81, 8'h7F, 8'h91, 8'h7E, 8'h71, 8'h01, 8'h8F, 8'h8E, 8'h82, 8'h80, 8'h40, 8'h72};
    logic [3:0] f[12] = '{4'h8, 4'h1, 4'h4, 4'h1, 4'h8, 4'h0, 4'h4, 4'h4, 4'h4, 4'h4, 4'h9, 4'h0};
    op(`CAD_OP_LDI, 5'h16, 5'h00, 8'h81);
    op(`CAD_OP_LDI, 5'h17, 5'h00, 8'h0F);
    for (int k = 0; k < 12; k++)
    begin
      op(`CAD_OP_MOV, 5'h18, 5'h16);
      op(o[k], 5'h18, 5'h17, 8'h0F);
      idle;
      cmp("op flags", f[k], o_flags[3:0]);
      st(5'h18, r[k]);
    end
    op(`CAD_OP_OUT, 5'h16, 5'h00, 8'h05);
    idle;
    cmp("out write", 16'h8581, {o_io_we, 1'b0, o_io_addr, o_io_wdata});
    op(`CAD_OP_BTST, 5'h07, 5'h00, 8'h1F, 16'h1900, 3'h7);
    op(`CAD_OP_BTST, 5'h07, 5'h00, 8'h1F, 16'h1900, 3'h5);
    #1;
    cmp("skip on bit", 16'h0002, {o_skip, o_io_we});
    idle;
    cmp("no skip", 16'h0000, {o_skip, o_io_we});
  endtask
  // Fetch stream must pick up where it left off after the steal
  task automatic s_lpm;
    logic [15:0] p;
    op(`CAD_OP_LDI, 5'h1E, 5'h00, 8'h07);
    op(`CAD_OP_LDI, 5'h1F, 5'h00, 8'h00);
    #1;
    p = o_pmem_addr;
    op(`CAD_OP_LPM, 5'h05);
    idle;
    cmp("code address", 16'h0003, o_pmem_addr);
    idle;
    cmp("fetch resumed", p + 16'h0002, o_pmem_addr);
    st(5'h05, 16'h0059);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset for 8 cycles, then the scenarios in turn
  initial
  begin
    repeat (7) @(posedge i_clk_sys);
    #1;
    cmp("flags in reset", `CAD_FLAGS_RST, o_flags);
    @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    s_fetch;
    s_alu;
    s_word;
    s_mul;
    s_io;
    s_ops;
    s_lpm;
    final_report;
  end
endmodule // test_cpu_alu_datapath
bind cad_core cad_core_assertions i_chk (.*);
